// ### evse_pkg.sv
// Purpose: Shared constants, types and register map for the charge station sequencer
// Assumes: 200 MHz clock, APB slave with 32-bit data
// Notes: Register offsets are byte addresses
package evse_pkg;
  localparam int CLK_HZ = 200_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int SAMPLES_PER_TICK = 4000;
  localparam int NUM_BLOCKS = 64;
  localparam int BLK_AW = 6;
  localparam int SAMP_W = 16;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  localparam logic [11:0] OFF_FAULT = 12'h010;
  localparam logic [11:0] OFF_GOOD = 12'h100;
  localparam logic [11:0] OFF_CARD = 12'h200;
  localparam logic [11:0] BLK_MASK = 12'hF00;
  localparam logic [31:0] GOOD_RESET = 32'h00000000;
  localparam int IRQ_CARD = 0;
  localparam int IRQ_STATE = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;
  localparam int FLT_SELF = 0;
  localparam int FLT_GROUND = 1;
  localparam int FLT_RELAY = 2;
  localparam int FLT_PILOT = 3;
  localparam int FLT_W = 4;

  // Supervisory states, Gray along the charging path
  typedef enum logic [3:0] {
    ST_START = 4'h0, ST_IDLE = 4'h1, ST_GF_CHECK = 4'h3, ST_GF_EXPECT = 4'h2,
    ST_GF_PASS = 4'h6, ST_A = 4'h7, ST_B = 4'h5, ST_C = 4'h4, ST_D = 4'hC, ST_FAULT = 4'hD
  } sup_e;

  // Card read steps
  typedef enum logic [2:0] {
    RD_IDLE = 3'h0, RD_INVENTORY = 3'h1, RD_INFO = 3'h3, RD_BLOCKS = 3'h2,
    RD_FORMAT = 3'h6, RD_DATA = 3'h7, RD_CHECK = 3'h5
  } rd_e;

  // Pilot classification reported by the far side
  typedef enum logic [2:0] {
    PV_HIGH = 3'h0, PV_DROP = 3'h1, PV_READY = 3'h2, PV_VENT = 3'h3, PV_BAD = 3'h4
  } pilot_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic valid;
    logic [31:0] data;
  } card_word_s;
endpackage : evse_pkg

// ### ev_charge_station_sequencer.sv
// Purpose: Supervisory sequencer for a pilot-wire charge station with card authorisation
// Assumes: Inputs synchronous to clk; reader transceiver supplies block words on request
// Notes: Card image and known-good image held in local arrays
//
// Notes on behaviour
// [R01] Idle keeps polling for cards; accepted card starts self test, else stay idle.
// [R02] Self test sets the test-expected flag and pulses the test coil in the same cycle.
// [R03] Ground detection with expected flag set is benign; otherwise ground fault.
// [R04] Expected state: pulse seen passes, not seen records self-test fault.
// [R05] Test-passed state takes no charging action.
// [R06] State A drives pilot static high; leaves to B only on voltage drop.
// [R07] In State A any other pilot report gives a pilot fault; the code stays in A without a fault on PV_HIGH.
// [R08] State B enables pilot PWM; exits only to C, A or fault.
// [R09] State C closes relay; exits to B, A, D or fault.
// [R10] State D returns only to C or fault.
// [R11] Four critical faults latch; fault state held until restart.
// [R12] State evaluation once per one-second tick from sample count.
// [R13] Card read walks inventory, info, blocks, format, data reads per tick.
// [R14] Complete read returns reader to idle and flags data available.
// [R15] All 64 card blocks are copied into a readable buffer.
// [R16] Acceptance compares card data bytewise to one stored good image.
// [R17] Transceiver raises its interrupt line for a new card while polling.
// [R18] Reset passes start into idle, relay open, PWM off, faults clear.
// [R19] Test-passed advances to State A on next tick when no fault is latched.
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
module ev_charge_station_sequencer #(
  parameter int TICK_SAMPLES = evse_pkg::SAMPLES_PER_TICK
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire evse_pkg::apb_req_s apbReq,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic sampleStrobe,
  input wire evse_pkg::pilot_e pilotLevel,
  input wire logic groundDetect,
  input wire logic relayStuck,
  input wire logic readerIrq,
  input wire evse_pkg::card_word_s readerWord,
  output logic readerReq,
  output logic [evse_pkg::BLK_AW-1:0] readerBlock,
  output logic pilotHigh,
  output logic pilotPwm,
  output logic relayClose,
  output logic testCoil,
  output logic irq
);
  import evse_pkg::*;

  typedef struct packed {
    sup_e sup;
    rd_e rd;
    logic [SAMP_W-1:0] sampCnt;
    logic tick;
    logic expectFlag;
    logic testSeen;
    logic [FLT_W-1:0] faults;
    logic [BLK_AW-1:0] blk;
    logic dataReady;
    logic enable;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic readerReq;
    logic pilotHigh;
    logic pilotPwm;
    logic relayClose;
    logic testCoil;
    logic irq;
  } state_s;

  state_s cur;
  state_s nxt;
  logic [31:0] cardMem [NUM_BLOCKS];
  logic [31:0] goodMem [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0] blkMatch;
  logic cardOk;
  logic apbWr;
  logic apbRd;
  logic [BLK_AW-1:0] apbIdx;

  // Bus decode
  assign apbWr = apbReq.psel && apbReq.penable && apbReq.pwrite && !cur.pready;
  assign apbRd = apbReq.psel && apbReq.penable && !apbReq.pwrite && !cur.pready;
  assign apbIdx = apbReq.paddr[BLK_AW+1:2];

  // Per-block compare against good image
  generate
    for (genvar gi = 0; gi < NUM_BLOCKS; gi++) begin : g_cmp
      assign blkMatch[gi] = (cardMem[gi] == goodMem[gi]); // R16
    end
  endgenerate
  assign cardOk = &blkMatch; // R16

  // Card and good image storage
  always_ff @(posedge clk) begin
    if (cur.rd == RD_DATA && readerWord.valid) begin
      cardMem[cur.blk] <= readerWord.data; // R15
    end
    if (apbWr && (apbReq.paddr & BLK_MASK) == OFF_GOOD) begin
      goodMem[apbIdx] <= apbReq.pwdata;
    end
  end

  // Next state
  always_comb begin
    nxt = cur;
    nxt.tick = 1'b0;
    nxt.testCoil = 1'b0;
    nxt.pready = 1'b0;
    nxt.pslverr = 1'b0;
    // Tick from sample count
    if (sampleStrobe) begin
      if (cur.sampCnt == SAMP_W'(TICK_SAMPLES - 1)) begin
        nxt.sampCnt = '0;
        nxt.tick = 1'b1; // R12
      end else begin
        nxt.sampCnt = cur.sampCnt + 1'b1;
      end
    end
    // Ground detection watch
    if (groundDetect) begin
      if (cur.expectFlag) begin
        nxt.testSeen = 1'b1; // R03
      end else begin
        nxt.faults[FLT_GROUND] = 1'b1; // R03
      end
    end
    if (relayStuck && cur.relayClose == 1'b0 && cur.sup != ST_START) begin
      nxt.faults[FLT_RELAY] = 1'b1; // R11
    end
    // Card reader sequencing, one step per tick
    if (cur.tick) begin
      unique case (cur.rd)
        RD_IDLE: begin
          if (cur.sup == ST_IDLE && cur.enable && readerIrq) begin // R01
            nxt.rd = RD_INVENTORY;
          end
        end
        RD_INVENTORY: nxt.rd = RD_INFO; // R13
        RD_INFO: nxt.rd = RD_BLOCKS; // R13
        RD_BLOCKS: nxt.rd = RD_FORMAT; // R13
        RD_FORMAT: begin
          nxt.rd = RD_DATA; // R13
          nxt.blk = '0;
        end
        RD_DATA: begin
          if (cur.blk == BLK_AW'(NUM_BLOCKS - 1)) begin
            nxt.rd = RD_CHECK;
          end else begin
            nxt.blk = cur.blk + 1'b1; // R13
          end
        end
        RD_CHECK: begin
          nxt.rd = RD_IDLE; // R14
          nxt.dataReady = 1'b1; // R14
        end
        default: nxt.rd = RD_IDLE;
      endcase
    end
    nxt.readerReq = (cur.rd != RD_IDLE) && (cur.rd != RD_CHECK);
    // Supervisory machine
    if (cur.sup == ST_START) begin
      nxt.sup = ST_IDLE; // R18
    end else if (cur.faults != '0) begin
      nxt.sup = ST_FAULT; // R11
    end else if (cur.tick) begin // R12
      unique case (cur.sup)
        ST_IDLE: begin
          if (cur.dataReady) begin
            nxt.dataReady = 1'b0;
            nxt.sup = cardOk ? ST_GF_CHECK : ST_IDLE; // R01
          end
        end
        ST_GF_CHECK: begin
          nxt.expectFlag = 1'b1; // R02
          nxt.testSeen = 1'b0;
          nxt.testCoil = 1'b1; // R02
          nxt.sup = ST_GF_EXPECT;
        end
        ST_GF_EXPECT: begin
          nxt.expectFlag = 1'b0;
          if (cur.testSeen) begin
            nxt.sup = ST_GF_PASS; // R04
          end else begin
            nxt.faults[FLT_SELF] = 1'b1; // R04
            nxt.sup = ST_FAULT;
          end
        end
        ST_GF_PASS: nxt.sup = ST_A; // R05 R19
        ST_A: begin
          if (pilotLevel == PV_DROP) begin
            nxt.sup = ST_B; // R06
          end else if (pilotLevel != PV_HIGH) begin
            nxt.faults[FLT_PILOT] = 1'b1; // R07
            nxt.sup = ST_FAULT;
          end
        end
        ST_B: begin
          unique case (pilotLevel)
            PV_READY: nxt.sup = ST_C; // R08
            PV_HIGH: nxt.sup = ST_A; // R08
            PV_DROP: nxt.sup = ST_B;
            default: begin
              nxt.faults[FLT_PILOT] = 1'b1; // R08
              nxt.sup = ST_FAULT;
            end
          endcase
        end
        ST_C: begin
          unique case (pilotLevel)
            PV_DROP: nxt.sup = ST_B; // R09
            PV_HIGH: nxt.sup = ST_A; // R09
            PV_VENT: nxt.sup = ST_D; // R09
            PV_READY: nxt.sup = ST_C;
            default: begin
              nxt.faults[FLT_PILOT] = 1'b1; // R09
              nxt.sup = ST_FAULT;
            end
          endcase
        end
        ST_D: begin
          if (pilotLevel == PV_READY) begin
            nxt.sup = ST_C; // R10
          end else if (pilotLevel != PV_VENT) begin
            nxt.faults[FLT_PILOT] = 1'b1; // R10
            nxt.sup = ST_FAULT;
          end
        end
        ST_FAULT: nxt.sup = ST_FAULT; // R11
        default: nxt.sup = ST_FAULT;
      endcase
    end
    // Outputs by state
    nxt.pilotHigh = (nxt.sup == ST_A) || (nxt.sup == ST_B) || (nxt.sup == ST_C) || (nxt.sup == ST_D); // R06
    nxt.pilotPwm = (nxt.sup == ST_B) || (nxt.sup == ST_C) || (nxt.sup == ST_D); // R08
    nxt.relayClose = (nxt.sup == ST_C) || (nxt.sup == ST_D); // R09
    // Interrupt events, set wins over clear
    if (apbWr && apbReq.paddr == OFF_IRQ_STAT) begin
      nxt.irqStat = cur.irqStat & ~apbReq.pwdata[IRQ_W-1:0];
    end
    if (apbWr && apbReq.paddr == OFF_IRQ_MASK) begin
      nxt.irqMask = apbReq.pwdata[IRQ_W-1:0];
    end
    if (apbWr && apbReq.paddr == OFF_CTRL) begin
      nxt.enable = apbReq.pwdata[0];
    end
    if (cur.rd == RD_CHECK && cur.tick) begin
      nxt.irqStat[IRQ_CARD] = 1'b1;
    end
    if (nxt.sup != cur.sup) begin
      nxt.irqStat[IRQ_STATE] = 1'b1;
    end
    if (nxt.faults != cur.faults) begin
      nxt.irqStat[IRQ_FAULT] = 1'b1;
    end
    nxt.irq = |(nxt.irqStat & nxt.irqMask);
    // APB answer, one wait state
    if (apbWr || apbRd) begin
      nxt.pready = 1'b1;
      nxt.prdata = '0;
      if ((apbReq.paddr & BLK_MASK) == OFF_CARD) begin
        if (apbRd) begin
          nxt.prdata = cardMem[apbIdx]; // R15
        end
      end else if ((apbReq.paddr & BLK_MASK) == OFF_GOOD) begin
        if (apbRd) begin
          nxt.prdata = goodMem[apbIdx];
        end
      end else begin
        unique case (apbReq.paddr)
          OFF_CTRL: nxt.prdata = {31'h0, cur.enable};
          OFF_STATUS: nxt.prdata = {21'h0, cur.dataReady, cur.rd, 2'h0, cur.expectFlag, cur.sup};
          OFF_IRQ_STAT: nxt.prdata = {29'h0, cur.irqStat};
          OFF_IRQ_MASK: nxt.prdata = {29'h0, cur.irqMask};
          OFF_FAULT: nxt.prdata = {28'h0, cur.faults};
          default: nxt.pslverr = 1'b1;
        endcase
      end
    end
    // Synchronous reset
    if (!rst_n) begin
      nxt = '0;
      nxt.sup = ST_START; // R18
      nxt.rd = RD_IDLE;
      nxt.enable = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    cur <= nxt;
  end

  assign pready = cur.pready;
  assign prdata = cur.prdata;
  assign pslverr = cur.pslverr;
  assign readerReq = cur.readerReq;
  assign readerBlock = cur.blk;
  assign pilotHigh = cur.pilotHigh;
  assign pilotPwm = cur.pilotPwm;
  assign relayClose = cur.relayClose;
  assign testCoil = cur.testCoil;
  assign irq = cur.irq;

  // Sequences and checks along the supervisory path
  sequence s_pass_entry;
    cur.sup == ST_GF_PASS && cur.tick;
  endsequence
  sequence s_coil_pulse;
    testCoil ##1 !testCoil;
  endsequence

  AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R01
    (cur.sup == ST_IDLE && cur.tick && !cur.dataReady && cur.faults == '0) |=> cur.sup == ST_IDLE)
    else $error("idle left without card");
  AST_COIL: assert property (@(posedge clk) disable iff (!rst_n) // R02
    testCoil |-> cur.expectFlag && cur.sup == ST_GF_EXPECT)
    else $error("coil pulse without expected flag");
  AST_COIL_ONE: assert property (@(posedge clk) disable iff (!rst_n) // R02
    $rose(testCoil) |-> s_coil_pulse)
    else $error("coil pulse longer than one cycle");
  AST_GROUND: assert property (@(posedge clk) disable iff (!rst_n) // R03
    (groundDetect && !cur.expectFlag && cur.sup != ST_START) |=> cur.faults[FLT_GROUND])
    else $error("ground event not latched");
  AST_SELFTEST: assert property (@(posedge clk) disable iff (!rst_n) // R04
    (cur.sup == ST_GF_EXPECT && cur.tick && !cur.testSeen && !groundDetect && cur.faults == '0)
    |=> cur.faults[FLT_SELF])
    else $error("missing self test fault");
  AST_PASS_A: assert property (@(posedge clk) disable iff (!rst_n) // R19
    s_pass_entry ##0 (cur.faults == '0) |=> cur.sup == ST_A ##1 pilotHigh && !pilotPwm && !relayClose)
    else $error("pass did not advance to A");
  AST_PILOT_A: assert property (@(posedge clk) disable iff (!rst_n) // R07
    (cur.sup == ST_A && cur.tick && cur.faults == '0 && pilotLevel != PV_DROP && pilotLevel != PV_HIGH)
    |=> cur.faults[FLT_PILOT])
    else $error("pilot fault missed in A");
  AST_RELAY: assert property (@(posedge clk) disable iff (!rst_n) // R09
    relayClose |-> cur.sup == ST_C || cur.sup == ST_D)
    else $error("relay closed outside C or D");
  AST_D_EXIT: assert property (@(posedge clk) disable iff (!rst_n) // R10
    (cur.sup == ST_D && nxt.sup != ST_D) |-> nxt.sup == ST_C || nxt.sup == ST_FAULT)
    else $error("illegal exit from D");
  AST_FAULT_HOLD: assert property (@(posedge clk) disable iff (!rst_n) // R11
    cur.sup == ST_FAULT |=> cur.sup == ST_FAULT && !relayClose)
    else $error("fault state left");
  AST_TICK: assert property (@(posedge clk) disable iff (!rst_n) // R12
    cur.tick |=> !cur.tick)
    else $error("tick longer than one cycle");
  AST_READ_DONE: assert property (@(posedge clk) disable iff (!rst_n) // R14
    (cur.rd == RD_CHECK && cur.tick) |=> cur.rd == RD_IDLE && cur.dataReady)
    else $error("read completion not flagged");
  AST_RESET: assert property (@(posedge clk) // R18
    $rose(rst_n) |-> cur.sup == ST_START && cur.faults == '0 && !relayClose && !pilotPwm ##1 cur.sup == ST_IDLE)
    else $error("reset did not pass start");
  // Exit checks for A and B, PWM output check, stuck relay and card event checks
  AST_A_EXIT: assert property (@(posedge clk) disable iff (!rst_n) // R06
    (cur.sup == ST_A && nxt.sup != ST_A) |-> nxt.sup == ST_B || nxt.sup == ST_FAULT)
    else $error("illegal exit from A");
  AST_B_EXIT: assert property (@(posedge clk) disable iff (!rst_n) // R08
    (cur.sup == ST_B && nxt.sup != ST_B) |-> nxt.sup == ST_C || nxt.sup == ST_A || nxt.sup == ST_FAULT)
    else $error("illegal exit from B");
  AST_PWM: assert property (@(posedge clk) disable iff (!rst_n) // R08
    pilotPwm |-> pilotHigh && (cur.sup == ST_B || cur.sup == ST_C || cur.sup == ST_D))
    else $error("pwm outside B C or D");
  AST_RELAY_FAULT: assert property (@(posedge clk) disable iff (!rst_n) // R11
    (relayStuck && !relayClose && cur.sup != ST_START) |=> cur.faults[FLT_RELAY])
    else $error("stuck relay not latched");
  AST_CARD_IRQ: assert property (@(posedge clk) disable iff (!rst_n) // R14
    (cur.rd == RD_CHECK && cur.tick) |=> cur.irqStat[IRQ_CARD])
    else $error("card read event not flagged");
endmodule : ev_charge_station_sequencer

// ### ev_far_side.sv
// Purpose: Far side model: vehicle on the pilot wire and card reader transceiver
// Assumes: Card word n reads as CARD_BASE | n; coil pulse echoes as a detect pulse
// Notes: Unrequested data line shows the inverse of its last value
`timescale 1ns/10ps
module ev_far_side #(
  parameter logic [31:0] CARD_BASE = 32'hC0DE0000
) (
  input wire logic clk,
  input wire logic cardPresent,
  input wire evse_pkg::pilot_e pilotCmd,
  input wire logic readerReq,
  input wire logic [evse_pkg::BLK_AW-1:0] readerBlock,
  input wire logic testCoil,
  output evse_pkg::pilot_e pilotLevel,
  output logic readerIrq,
  output evse_pkg::card_word_s readerWord,
  output logic groundDetect
);
  import evse_pkg::*;
  logic [31:0] lastData = 32'h0;
  // Vehicle state as commanded
  assign pilotLevel = pilotCmd;
  // New card flagged only while polling
  assign readerIrq = cardPresent && !readerReq;
  // Block word while requested, changing pattern otherwise
  assign readerWord = '{valid: readerReq, data: (readerReq ? (CARD_BASE | 32'(readerBlock)) : ~lastData)};
  // Last word and coil echo
  always_ff @(posedge clk) begin
    lastData <= readerWord.data;
    groundDetect <= testCoil;
  end
endmodule : ev_far_side

// ### tb_ev_charge_station_sequencer.sv
// Purpose: Self-checking bench for the charge station sequencer
// Assumes: Sample strobe high every cycle, so one tick per TICK_SAMPLES cycles
// Notes: Good image first differs in block 5, then is corrected
`timescale 1ns/10ps
module tb_ev_charge_station_sequencer;
  import evse_pkg::*;
  localparam logic [31:0] CARD_BASE = 32'hC0DE0000;
  // Short tick keeps the run small; the counting logic is the same at any length
  localparam int TICK_SAMPLES = 32;
  typedef struct packed {logic [11:0] addr; logic [31:0] exp; logic err;} row_s;
  typedef struct packed {pilot_e p; sup_e s; logic [2:0] o;} step_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sampleStrobe = 1'b1;
  logic relayStuck = 1'b0;
  logic cardPresent = 1'b1;
  apb_req_s apbReq = '0;
  pilot_e pilotCmd = PV_HIGH;
  pilot_e pilotLevel;
  card_word_s readerWord;
  logic [BLK_AW-1:0] readerBlock;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, groundDetect, readerIrq, readerReq;
  logic pilotHigh, pilotPwm, relayClose, testCoil, irq;
  int errCount = 0;
  int checks = 0;
  int coilCount = 0;

  // Clock and coil pulse count
  always #2.5 clk = ~clk;
  always @(posedge clk) if (testCoil === 1'b1) coilCount++;

  ev_charge_station_sequencer #(.TICK_SAMPLES(TICK_SAMPLES)) i_ev_charge_station_sequencer (.clk(clk),
    .rst_n(rst_n), .apbReq(apbReq),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sampleStrobe(sampleStrobe),
    .pilotLevel(pilotLevel), .groundDetect(groundDetect), .relayStuck(relayStuck), .readerIrq(readerIrq),
    .readerWord(readerWord), .readerReq(readerReq), .readerBlock(readerBlock), .pilotHigh(pilotHigh),
    .pilotPwm(pilotPwm), .relayClose(relayClose), .testCoil(testCoil), .irq(irq));
  ev_far_side #(.CARD_BASE(CARD_BASE)) i_ev_far_side (.clk(clk), .cardPresent(cardPresent),
    .pilotCmd(pilotCmd), .readerReq(readerReq), .readerBlock(readerBlock), .testCoil(testCoil),
    .pilotLevel(pilotLevel), .readerIrq(readerIrq), .readerWord(readerWord), .groundDetect(groundDetect));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // One APB transfer, held until pready, then released
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    rd = prdata;
    err = pslverr;
    apbReq <= '0;
    @(posedge clk);
  endtask : apb

  task automatic waitSup(input sup_e s, input int ticks);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_STATUS, '0);
      n++;
    end while (rd[3:0] !== s && n < ticks * TICK_SAMPLES / 4 + 10);
    check(32'(rd[3:0]), 32'(s));
  endtask : waitSup

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog
  initial begin
    repeat (400 * TICK_SAMPLES) @(posedge clk);
    errCount++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    row_s rows [6];
    step_s steps [7];
    int n;
    rows = '{'{OFF_CTRL, 32'h1, 1'b0}, '{OFF_STATUS, 32'h1, 1'b0}, '{OFF_IRQ_STAT, 32'h2, 1'b0},
      '{OFF_IRQ_MASK, 32'h0, 1'b0}, '{OFF_FAULT, 32'h0, 1'b0}, '{12'h020, 32'h0, 1'b1}};
    steps = '{'{PV_DROP, ST_B, 3'h6}, '{PV_READY, ST_C, 3'h7}, '{PV_VENT, ST_D, 3'h7},
      '{PV_READY, ST_C, 3'h7}, '{PV_DROP, ST_B, 3'h6}, '{PV_HIGH, ST_A, 3'h4}, '{PV_BAD, ST_FAULT, 3'h0}};
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(32'({pilotHigh, pilotPwm, relayClose, testCoil, irq}), 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, rows[i].addr, '0);
      if (!rows[i].err) check(rd, rows[i].exp);
      check(32'(err), 32'(rows[i].err));
    end
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      apb(1'b1, OFF_GOOD + 12'(4 * i), CARD_BASE | 32'(i) ^ ((i == 5) ? 32'h1 : 32'h0));
    end
    apb(1'b1, OFF_IRQ_MASK, 32'h1 << IRQ_CARD);
    n = 0;
    while (irq !== 1'b1 && n < 100 * TICK_SAMPLES) begin
      n++;
      @(posedge clk);
    end
    check(32'(irq), 32'h1);
    apb(1'b1, OFF_IRQ_STAT, 32'h1 << IRQ_CARD);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    apb(1'b1, OFF_CARD, ~CARD_BASE);
    for (int i = 0; i < NUM_BLOCKS; i++) begin
      apb(1'b0, OFF_CARD + 12'(4 * i), '0);
      check(rd, CARD_BASE | 32'(i));
    end
    repeat (2 * TICK_SAMPLES) @(posedge clk);
    waitSup(ST_IDLE, 0);
    apb(1'b1, OFF_GOOD + 12'h014, CARD_BASE | 32'h5);
    waitSup(ST_GF_CHECK, 160);
    waitSup(ST_GF_EXPECT, 2);
    check(32'(coilCount), 32'h1);
    waitSup(ST_GF_PASS, 2);
    check(32'({pilotHigh, pilotPwm, relayClose}), 32'h0);
    waitSup(ST_A, 2);
    check(32'({pilotHigh, pilotPwm, relayClose}), 32'h4);
    for (int i = 0; i < 7; i++) begin
      pilotCmd <= steps[i].p;
      waitSup(steps[i].s, 2);
      check(32'({pilotHigh, pilotPwm, relayClose}), 32'(steps[i].o));
    end
    apb(1'b0, OFF_FAULT, '0);
    check(rd, 32'h1 << FLT_PILOT);
    pilotCmd <= PV_DROP;
    repeat (2 * TICK_SAMPLES) @(posedge clk);
    waitSup(ST_FAULT, 0);
    // Restart in mid-run clears the latched fault
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check(32'({pilotHigh, pilotPwm, relayClose, testCoil, irq}), 32'h0);
    apb(1'b0, OFF_FAULT, '0);
    check(rd, 32'h0);
    waitSup(ST_IDLE, 0);
    // Stuck relay while open latches its own fault
    relayStuck <= 1'b1;
    repeat (2) @(posedge clk);
    apb(1'b0, OFF_FAULT, '0);
    check(rd, 32'h1 << FLT_RELAY);
    waitSup(ST_FAULT, 0);
    report_and_stop();
  end
endmodule : tb_ev_charge_station_sequencer
